// *** hdl/jpdr_cmd_decode.v ***
// decodes one applied programming command against the memory mode
`timescale 1ns/100ps
`include "jpdr_defs.vh"
module jpdr_cmd_decode (
  // current mode and command fields
  input wire [2:0] i_mode,
  input wire [6:0] i_op,
  input wire [7:0] i_data,
  // decoded actions
  output reg o_mode_ld,
  output reg [2:0] o_mode_nxt,
  output reg o_erase,
  output reg o_wr_page,
  output reg o_latch,
  output reg o_addr_hi,
  output reg o_addr_lo,
  output reg o_data_lo,
  output reg o_data_hi,
  output reg o_rd_lo,
  output reg o_rd_hi
);

  wire wr_mode;
  wire rd_mode;

  assign wr_mode = (i_mode == `JPDR_MODE_FWR) || (i_mode == `JPDR_MODE_EWR);
  assign rd_mode = (i_mode == `JPDR_MODE_FRD) || (i_mode == `JPDR_MODE_ERD);

  always @* begin
    o_mode_ld = 1'b0;
    o_mode_nxt = `JPDR_MODE_NONE;
    o_erase = 1'b0;
    o_wr_page = 1'b0;
    o_latch = 1'b0;
    o_addr_hi = 1'b0;
    o_addr_lo = 1'b0;
    o_data_lo = 1'b0;
    o_data_hi = 1'b0;
    o_rd_lo = 1'b0;
    o_rd_hi = 1'b0;
    case (i_op)
      `JPDR_OP_ENTER: begin
        o_mode_ld = 1'b1;
        case (i_data)
          `JPDR_ENTER_ERASE: o_mode_nxt = `JPDR_MODE_ERASE;
          `JPDR_ENTER_FWR: o_mode_nxt = `JPDR_MODE_FWR;
          `JPDR_ENTER_FRD: o_mode_nxt = `JPDR_MODE_FRD;
          `JPDR_ENTER_EWR: o_mode_nxt = `JPDR_MODE_EWR;
          `JPDR_ENTER_ERD: o_mode_nxt = `JPDR_MODE_ERD;
          default: o_mode_nxt = `JPDR_MODE_NONE;
        endcase
      end
      `JPDR_OP_ADDR_HI: o_addr_hi = 1'b1;
      `JPDR_OP_ADDR_LO: o_addr_lo = 1'b1;
      `JPDR_OP_DATA_LO: o_data_lo = 1'b1;
      `JPDR_OP_DATA_HI: o_data_hi = 1'b1;
      `JPDR_OP_LATCH: o_latch = wr_mode;
      `JPDR_OP_FWR_GO: o_wr_page = (i_mode == `JPDR_MODE_FWR);
      `JPDR_OP_EGO: begin
        o_erase = (i_mode == `JPDR_MODE_ERASE);
        o_wr_page = (i_mode == `JPDR_MODE_EWR);
      end
      `JPDR_OP_RD_LO: o_rd_lo = rd_mode;
      `JPDR_OP_RD_HI: o_rd_hi = (i_mode == `JPDR_MODE_FRD);
      default: o_mode_ld = 1'b0;
    endcase
  end

endmodule

// *** hdl/jpdr_defs.vh ***
// constants for the jtag programming data registers
`ifndef JPDR_DEFS_VH
`define JPDR_DEFS_VH

// instruction codes held in the 4-bit instruction register
`define JPDR_IR_RESET 4'hc
`define JPDR_IR_UNLOCK 4'h4
`define JPDR_IR_CMD 4'h5
`define JPDR_IR_PLOAD 4'h6
`define JPDR_IR_PREAD 4'h7

// tap state codes reported by the tap controller
`define JPDR_ST_RTI 4'hc
`define JPDR_ST_CAPDR 4'h6
`define JPDR_ST_SHDR 4'h2
`define JPDR_ST_UPDDR 4'h5

// unlock register
`define JPDR_UNLOCK_W 16
`define JPDR_UNLOCK_SIG 16'ha370
`define JPDR_UNLOCK_RST 16'h0000

// command register: opcode above data/address field
`define JPDR_CMD_W 15
`define JPDR_CMD_OP_MSB 14
`define JPDR_CMD_OP_LSB 8
`define JPDR_CMD_DATA_MSB 7
`define JPDR_RES_READY_BIT 9

// page chains: 128 bytes, read chain has one leading dummy byte
`define JPDR_PAGE_IDX_W 7
`define JPDR_PAGE_LOAD_BITS 1024
`define JPDR_PAGE_READ_BITS 1032

// command opcodes
`define JPDR_OP_ENTER 7'h23
`define JPDR_OP_ADDR_HI 7'h07
`define JPDR_OP_ADDR_LO 7'h03
`define JPDR_OP_DATA_LO 7'h13
`define JPDR_OP_DATA_HI 7'h17
`define JPDR_OP_LATCH 7'h77
`define JPDR_OP_IDLE_HI 7'h37
`define JPDR_OP_FWR_GO 7'h35
`define JPDR_OP_IDLE_LO 7'h33
`define JPDR_OP_EGO 7'h31
`define JPDR_OP_RD_LO 7'h32
`define JPDR_OP_RD_HI 7'h36

// data field of the enter-mode command
`define JPDR_ENTER_ERASE 8'h80
`define JPDR_ENTER_FWR 8'h10
`define JPDR_ENTER_FRD 8'h02
`define JPDR_ENTER_EWR 8'h11
`define JPDR_ENTER_ERD 8'h03

// memory modes
`define JPDR_MODE_NONE 3'h0
`define JPDR_MODE_ERASE 3'h1
`define JPDR_MODE_FWR 3'h2
`define JPDR_MODE_FRD 3'h3
`define JPDR_MODE_EWR 3'h4
`define JPDR_MODE_ERD 3'h5

// core reset time-out after the reset chain clears, in cycles
`define JPDR_TOUT_W 20
`define JPDR_TOUT_SHORT_CYC 20'h00400
`define JPDR_TOUT_LONG_CYC 20'h10000

`endif

// *** hdl/jpdr_sync2.v ***
// two flip-flop synchroniser for signals from outside the clock domain
`timescale 1ns/100ps
module jpdr_sync2 #(
  parameter W = 1
) (
  // clock and reset
  input wire i_clk,
  input wire i_reset,
  // asynchronous in, synchronised out
  input wire [W-1:0] i_async,
  output wire [W-1:0] o_sync
);

  reg [W-1:0] meta_ff;
  reg [W-1:0] sync_ff;

  always @(posedge i_clk) begin
    if (i_reset) begin
      meta_ff <= {W{1'b0}};
      sync_ff <= {W{1'b0}};
    end else begin
      meta_ff <= i_async;
      sync_ff <= meta_ff;
    end
  end

  assign o_sync = sync_ff;

endmodule

// *** hdl/jpdr_top.v ***
// programming data registers behind the jtag port, sampled on sys clock
`timescale 1ns/100ps
`include "jpdr_defs.vh"
module jpdr_top #(
  parameter [19:0] P_TOUT_SHORT_CYC = `JPDR_TOUT_SHORT_CYC,
  parameter [19:0] P_TOUT_LONG_CYC = `JPDR_TOUT_LONG_CYC
) (
  // clock and reset
  input wire I_CLK_SYS,
  input wire I_RESET,
  // test port and tap controller
  input wire I_TCK,
  input wire I_TDI,
  input wire [3:0] I_TAP_STATE,
  input wire [3:0] I_TAP_IR,
  output reg O_TDO,
  output reg O_TDO_OE,
  // clock option fuses and core reset
  input wire [1:0] I_TOUT_SEL,
  output reg O_CORE_RESET,
  output reg O_PROG_EN,
  // applied command
  output reg [14:0] O_CMD_WORD,
  output reg O_CMD_CLK,
  // memory control
  output reg [2:0] O_MEM_MODE,
  output reg [15:0] O_MEM_ADDR,
  output reg [15:0] O_MEM_WDATA,
  output reg O_MEM_ERASE,
  output reg O_MEM_LATCH,
  output reg O_MEM_WRPAGE,
  output reg O_MEM_RD,
  output reg O_MEM_BYTE_HI,
  input wire I_MEM_READY,
  input wire [15:0] I_MEM_RDATA,
  // page buffer streaming
  output reg [6:0] O_PAGE_ADDR,
  output reg [7:0] O_PAGE_WDATA,
  output reg O_PAGE_WSTB,
  output reg O_PAGE_RSTB,
  input wire [7:0] I_PAGE_RDATA
);

  wire [9:0] tap_s;
  wire [1:0] tout_sel_s;
  wire tck_s;
  wire tdi_s;
  wire [3:0] st_s;
  wire [3:0] ir_s;
  reg tck_d_ff;
  reg [3:0] st_prev_ff;
  wire tck_rise;
  wire tck_fall;

  jpdr_sync2 #(.W(10)) u_sync_tap (
    .i_clk(I_CLK_SYS),
    .i_reset(I_RESET),
    .i_async({I_TCK, I_TDI, I_TAP_STATE, I_TAP_IR}),
    .o_sync(tap_s)
  );

  jpdr_sync2 #(.W(2)) u_sync_fuse (
    .i_clk(I_CLK_SYS),
    .i_reset(I_RESET),
    .i_async(I_TOUT_SEL),
    .o_sync(tout_sel_s)
  );

  assign tck_s = tap_s[9];
  assign tdi_s = tap_s[8];
  assign st_s = tap_s[7:4];
  assign ir_s = tap_s[3:0];
  assign tck_rise = tck_s & ~tck_d_ff;
  assign tck_fall = ~tck_s & tck_d_ff;

  // state qualifiers, valid on a tck rising edge
  wire in_cap;
  wire in_sh;
  wire in_upd;
  wire rti_entry;
  wire ir_ours;
  assign in_cap = tck_rise && (st_s == `JPDR_ST_CAPDR);
  assign in_sh = tck_rise && (st_s == `JPDR_ST_SHDR);
  assign in_upd = tck_rise && (st_s == `JPDR_ST_UPDDR);
  assign rti_entry = tck_rise && (st_s == `JPDR_ST_RTI) &&
                     (st_prev_ff != `JPDR_ST_RTI);
  assign ir_ours = (ir_s == `JPDR_IR_RESET) || (ir_s == `JPDR_IR_UNLOCK) ||
                   (ir_s == `JPDR_IR_CMD) || (ir_s == `JPDR_IR_PLOAD) ||
                   (ir_s == `JPDR_IR_PREAD);

  always @(posedge I_CLK_SYS) begin
    if (I_RESET) begin
      tck_d_ff <= 1'b0;
      st_prev_ff <= `JPDR_ST_RTI;
    end else begin
      tck_d_ff <= tck_s;
      if (tck_rise) begin
        st_prev_ff <= st_s;
      end
    end
  end

  // reset chain and core reset time-out
  reg rst_chain_ff;
  reg [19:0] tout_cnt_ff;
  reg [19:0] tout_len;

  always @* begin
    case (tout_sel_s)
      2'h0: tout_len = 20'h00000;
      2'h1: tout_len = P_TOUT_SHORT_CYC;
      default: tout_len = P_TOUT_LONG_CYC;
    endcase
  end

  always @(posedge I_CLK_SYS) begin
    if (I_RESET) begin
      rst_chain_ff <= 1'b0;
      tout_cnt_ff <= 20'h00000;
      O_CORE_RESET <= 1'b0;
    end else begin
      if (in_sh && ir_s == `JPDR_IR_RESET) begin
        rst_chain_ff <= tdi_s;
      end
      if (rst_chain_ff) begin
        tout_cnt_ff <= tout_len;
      end else if (tout_cnt_ff != 20'h00000) begin
        tout_cnt_ff <= tout_cnt_ff - 20'h00001;
      end
      // chain bit drives reset directly, no update stage
      O_CORE_RESET <= rst_chain_ff | (tout_cnt_ff != 20'h00000);
    end
  end

  // unlock chain
  reg [15:0] unl_sh_ff;
  reg [15:0] unl_ff;

  always @(posedge I_CLK_SYS) begin
    if (I_RESET) begin
      unl_sh_ff <= `JPDR_UNLOCK_RST;
      unl_ff <= `JPDR_UNLOCK_RST;
      O_PROG_EN <= 1'b0;
    end else begin
      if (ir_s == `JPDR_IR_UNLOCK) begin
        if (in_sh) begin
          unl_sh_ff <= {tdi_s, unl_sh_ff[15:1]};
        end
        if (in_upd) begin
          unl_ff <= unl_sh_ff;
        end
      end
      O_PROG_EN <= (unl_ff == `JPDR_UNLOCK_SIG);
    end
  end

  // command chain and memory control
  reg [14:0] cmd_sh_ff;
  wire [7:0] res_byte;
  wire [14:0] cmd_result;
  wire exec;
  wire dec_mode_ld;
  wire [2:0] dec_mode;
  wire dec_erase;
  wire dec_wr_page;
  wire dec_latch;
  wire dec_addr_hi;
  wire dec_addr_lo;
  wire dec_data_lo;
  wire dec_data_hi;
  wire dec_rd_lo;
  wire dec_rd_hi;

  assign res_byte = O_MEM_BYTE_HI ? I_MEM_RDATA[15:8] : I_MEM_RDATA[7:0];
  // ready flag at bit 9 serves all completion polls
  assign cmd_result = {5'h00, I_MEM_READY, 1'b0, res_byte};
  assign exec = rti_entry && (ir_s == `JPDR_IR_CMD) && O_PROG_EN;

  jpdr_cmd_decode u_dec (
    .i_mode(O_MEM_MODE),
    .i_op(O_CMD_WORD[`JPDR_CMD_OP_MSB:`JPDR_CMD_OP_LSB]),
    .i_data(O_CMD_WORD[`JPDR_CMD_DATA_MSB:0]),
    .o_mode_ld(dec_mode_ld),
    .o_mode_nxt(dec_mode),
    .o_erase(dec_erase),
    .o_wr_page(dec_wr_page),
    .o_latch(dec_latch),
    .o_addr_hi(dec_addr_hi),
    .o_addr_lo(dec_addr_lo),
    .o_data_lo(dec_data_lo),
    .o_data_hi(dec_data_hi),
    .o_rd_lo(dec_rd_lo),
    .o_rd_hi(dec_rd_hi)
  );

  always @(posedge I_CLK_SYS) begin
    if (I_RESET) begin
      cmd_sh_ff <= 15'h0000;
      O_CMD_WORD <= 15'h0000;
      O_CMD_CLK <= 1'b0;
      O_MEM_MODE <= `JPDR_MODE_NONE;
      O_MEM_ADDR <= 16'h0000;
      O_MEM_WDATA <= 16'h0000;
      O_MEM_ERASE <= 1'b0;
      O_MEM_LATCH <= 1'b0;
      O_MEM_WRPAGE <= 1'b0;
      O_MEM_RD <= 1'b0;
      O_MEM_BYTE_HI <= 1'b0;
    end else begin
      if (ir_s == `JPDR_IR_CMD) begin
        if (in_cap) begin
          cmd_sh_ff <= cmd_result;
        end else if (in_sh) begin
          cmd_sh_ff <= {tdi_s, cmd_sh_ff[14:1]};
        end
        if (in_upd && O_PROG_EN) begin
          O_CMD_WORD <= cmd_sh_ff;
        end
      end
      O_CMD_CLK <= exec;
      O_MEM_ERASE <= exec & dec_erase;
      O_MEM_LATCH <= exec & dec_latch;
      O_MEM_WRPAGE <= exec & dec_wr_page;
      O_MEM_RD <= exec & dec_rd_lo;
      if (exec) begin
        if (dec_mode_ld) begin
          O_MEM_MODE <= dec_mode;
        end
        if (dec_addr_hi) begin
          O_MEM_ADDR[15:8] <= O_CMD_WORD[7:0];
        end
        if (dec_addr_lo) begin
          O_MEM_ADDR[7:0] <= O_CMD_WORD[7:0];
        end
        if (dec_data_lo) begin
          O_MEM_WDATA[7:0] <= O_CMD_WORD[7:0];
        end
        if (dec_data_hi) begin
          O_MEM_WDATA[15:8] <= O_CMD_WORD[7:0];
        end
        if (dec_rd_lo) begin
          O_MEM_BYTE_HI <= 1'b0;
        end else if (dec_rd_hi) begin
          O_MEM_BYTE_HI <= 1'b1;
        end
      end
    end
  end

  // page-load and page-read chains share one 8-bit shifter
  reg [7:0] pg_sh_ff;
  reg [2:0] pg_bit_ff;
  reg [6:0] pg_idx_ff;
  wire pg_load;
  wire pg_read;
  wire [7:0] pg_next;

  assign pg_load = (ir_s == `JPDR_IR_PLOAD) && O_PROG_EN;
  assign pg_read = (ir_s == `JPDR_IR_PREAD) && O_PROG_EN;
  assign pg_next = {tdi_s, pg_sh_ff[7:1]};

  always @(posedge I_CLK_SYS) begin
    if (I_RESET) begin
      pg_sh_ff <= 8'h00;
      pg_bit_ff <= 3'h0;
      pg_idx_ff <= 7'h00;
      O_PAGE_ADDR <= 7'h00;
      O_PAGE_WDATA <= 8'h00;
      O_PAGE_WSTB <= 1'b0;
      O_PAGE_RSTB <= 1'b0;
    end else begin
      O_PAGE_WSTB <= 1'b0;
      O_PAGE_RSTB <= 1'b0;
      if ((pg_load || pg_read) && in_cap) begin
        // restart at byte 0; shifter content is not loaded
        pg_bit_ff <= 3'h0;
        pg_idx_ff <= 7'h00;
        O_PAGE_ADDR <= 7'h00;
      end else if (pg_load && in_sh) begin
        pg_sh_ff <= pg_next;
        pg_bit_ff <= pg_bit_ff + 3'h1;
        if (pg_bit_ff == 3'h7) begin
          O_PAGE_WDATA <= pg_next;
          O_PAGE_WSTB <= 1'b1;
          O_PAGE_ADDR <= pg_idx_ff;
          pg_idx_ff <= pg_idx_ff + 7'h01;
        end
      end else if (pg_read && in_sh) begin
        pg_bit_ff <= pg_bit_ff + 3'h1;
        if (pg_bit_ff == 3'h7) begin
          // first eight bits out are the dummy byte
          pg_sh_ff <= I_PAGE_RDATA;
          O_PAGE_RSTB <= 1'b1;
          O_PAGE_ADDR <= pg_idx_ff + 7'h01;
          pg_idx_ff <= pg_idx_ff + 7'h01;
        end else begin
          pg_sh_ff <= {1'b0, pg_sh_ff[7:1]};
        end
      end
    end
  end

  // tdo changes on the falling tck edge
  reg tdo_sel;
  always @* begin
    case (ir_s)
      `JPDR_IR_RESET: tdo_sel = rst_chain_ff;
      `JPDR_IR_UNLOCK: tdo_sel = unl_sh_ff[0];
      `JPDR_IR_CMD: tdo_sel = cmd_sh_ff[0];
      `JPDR_IR_PLOAD: tdo_sel = pg_sh_ff[0];
      `JPDR_IR_PREAD: tdo_sel = pg_sh_ff[0];
      default: tdo_sel = 1'b0;
    endcase
  end

  always @(posedge I_CLK_SYS) begin
    if (I_RESET) begin
      O_TDO <= 1'b0;
      O_TDO_OE <= 1'b0;
    end else if (tck_fall) begin
      O_TDO <= tdo_sel;
      O_TDO_OE <= ir_ours && (st_s == `JPDR_ST_SHDR);
    end
  end

endmodule

// *** test/jpdr_prog.sv ***
// programmer model driving the test port of the block
`timescale 1ns/100ps
`include "jpdr_defs.vh"
module jpdr_prog (
  // test port towards the block
  output reg o_tck,
  output reg o_tdi,
  output reg [3:0] o_state,
  output reg [3:0] o_ir,
  input wire i_tdo
);
  reg [1031:0] q_page;
  initial begin
    o_tck = 1'b0;
    o_tdi = 1'b0;
    o_state = `JPDR_ST_RTI;
    o_ir = `JPDR_IR_RESET;
  end
  // one tck period; tck stands low between calls
  task tck(input [3:0] st, input b, output t);
    begin
      o_state = st;
      o_tdi = b;
      #62.5 t = i_tdo;
      o_tck = 1'b1;
      #62.5 o_tck = 1'b0;
    end
  endtask
  // capture, n shifts, update, one run-test/idle pass
  task scan(input [3:0] ir, input integer n, input [15:0] d,
    output [15:0] q);
    integer i;
    reg t;
    begin
      q = 16'h0000;
      o_ir = ir;
      tck(`JPDR_ST_CAPDR, 1'b0, t);
      for (i = 0; i < n; i = i + 1) begin
        tck(`JPDR_ST_SHDR, d[i], t);
        q[i] = t;
      end
      tck(`JPDR_ST_UPDDR, 1'b0, t);
      tck(`JPDR_ST_RTI, 1'b0, t);
    end
  endtask
  // page stream, byte k carries k^5a; this part is alone in the chain
  task page(input [3:0] ir, input integer n);
    integer i;
    reg t;
    reg [7:0] v;
    begin
      o_ir = ir;
      tck(`JPDR_ST_CAPDR, 1'b0, t);
      for (i = 0; i < n; i = i + 1) begin
        v = i[10:3] ^ 8'h5a;
        tck(`JPDR_ST_SHDR, v[i[2:0]], t);
        q_page[i] = t;
      end
      tck(`JPDR_ST_UPDDR, 1'b0, t);
      tck(`JPDR_ST_RTI, 1'b0, t);
    end
  endtask
endmodule

// *** test/jpdr_top_assertions.sv ***
// checker for the command and page outputs of the programming registers
`timescale 1ns/100ps
`include "jpdr_defs.vh"
module jpdr_top_assertions (
  // clock and reset
  input wire I_CLK_SYS,
  input wire I_RESET,
  // watched outputs
  input wire O_PROG_EN,
  input wire [14:0] O_CMD_WORD,
  input wire O_CMD_CLK,
  input wire [2:0] O_MEM_MODE,
  input wire [15:0] O_MEM_ADDR,
  input wire [15:0] O_MEM_WDATA,
  input wire O_MEM_ERASE,
  input wire O_MEM_LATCH,
  input wire O_MEM_WRPAGE,
  input wire O_MEM_RD,
  input wire O_PAGE_WSTB,
  input wire O_PAGE_RSTB
);
  default clocking cb @(posedge I_CLK_SYS);
  endclocking
  default disable iff (I_RESET);
  wire [6:0] op = O_CMD_WORD[14:8];
  wire [7:0] fld = O_CMD_WORD[7:0];
  wire any_mem = O_MEM_ERASE | O_MEM_LATCH | O_MEM_WRPAGE | O_MEM_RD;
  wire is_fwr = O_MEM_MODE == `JPDR_MODE_FWR;
  wire is_ewr = O_MEM_MODE == `JPDR_MODE_EWR;
  clk_pulse_a: assert property (O_CMD_CLK |=> !O_CMD_CLK)
    else $error("command clock wider than one cycle");
  mem_on_clk_a: assert property (any_mem |-> O_CMD_CLK)
    else $error("memory pulse without command clock");
  locked_quiet_a: assert property (
    !O_PROG_EN |-> !any_mem && !O_PAGE_WSTB && !O_PAGE_RSTB)
    else $error("memory action while locked");
  erase_cmd_a: assert property (O_MEM_ERASE |->
    O_MEM_MODE == `JPDR_MODE_ERASE && op == `JPDR_OP_EGO)
    else $error("erase from wrong command");
  wrpage_cmd_a: assert property (O_MEM_WRPAGE |->
    is_fwr && op == `JPDR_OP_FWR_GO || is_ewr && op == `JPDR_OP_EGO)
    else $error("page write from wrong command");
  latch_cmd_a: assert property (O_MEM_LATCH |->
    op == `JPDR_OP_LATCH && (is_fwr || is_ewr))
    else $error("latch from wrong command");
  rd_cmd_a: assert property (O_MEM_RD |-> op == `JPDR_OP_RD_LO)
    else $error("read from wrong command");
  mode_src_a: assert property (
    !$stable(O_MEM_MODE) |-> O_CMD_CLK && op == `JPDR_OP_ENTER)
    else $error("mode changed without enter command");
  addr_lo_a: assert property (
    O_CMD_CLK && op == `JPDR_OP_ADDR_LO |-> O_MEM_ADDR[7:0] == fld)
    else $error("low address not loaded");
  data_lo_a: assert property (
    O_CMD_CLK && op == `JPDR_OP_DATA_LO |-> O_MEM_WDATA[7:0] == fld)
    else $error("low data not loaded");
  wstb_gap_a: assert property (O_PAGE_WSTB |=> !O_PAGE_WSTB [*8])
    else $error("page strobes too close");
  erase_c: cover property (O_MEM_ERASE);
  latch_c: cover property (O_MEM_LATCH);
  wrpage_c: cover property (O_MEM_WRPAGE);
  wstb_c: cover property (O_PAGE_WSTB);
endmodule
bind jpdr_top jpdr_top_assertions u_chk (
  .I_CLK_SYS(I_CLK_SYS), .I_RESET(I_RESET), .O_PROG_EN(O_PROG_EN),
  .O_CMD_WORD(O_CMD_WORD), .O_CMD_CLK(O_CMD_CLK), .O_MEM_MODE(O_MEM_MODE),
  .O_MEM_ADDR(O_MEM_ADDR), .O_MEM_WDATA(O_MEM_WDATA),
  .O_MEM_ERASE(O_MEM_ERASE), .O_MEM_LATCH(O_MEM_LATCH),
  .O_MEM_WRPAGE(O_MEM_WRPAGE), .O_MEM_RD(O_MEM_RD),
  .O_PAGE_WSTB(O_PAGE_WSTB), .O_PAGE_RSTB(O_PAGE_RSTB)
);

// *** test/jpdr_top_tb.sv ***
// self-checking bench for the programming data registers
`timescale 1ns/100ps
`include "jpdr_defs.vh"
module jpdr_top_tb;
  localparam [47:0] ENT_D = {8'h80, 8'h10, 8'h02, 8'h11, 8'h03, 8'h44};
  localparam [17:0] ENT_M = {3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h0};
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg [1:0] tout_sel = 2'h0;
  reg mem_ready = 1'b1;
  reg [15:0] mem_rdata = 16'hc35a;
  wire tck, tdi, tdo, tdo_oe, core_rst, prog_en, cmd_clk;
  wire erase, latch, wrpage, rd, byte_hi, wstb, rstb;
  wire [3:0] state, ir;
  wire [14:0] cmd_word;
  wire [2:0] mem_mode;
  wire [15:0] mem_addr, mem_wdata;
  wire [6:0] page_addr;
  wire [7:0] page_wdata;
  wire [7:0] page_rdata = {1'b1, page_addr} ^ 8'h3c;
  integer n_errors = 0, checks_done = 0, cyc = 0, rst_len = 0;
  integer c_cmd = 0, c_er = 0, c_lat = 0, c_wr = 0, c_rd = 0, c_ws = 0;
  integer c_rs = 0, c_oe = 0;
  reg [7:0] pg [0:127];
  reg [15:0] r;
  always #2 clk = ~clk;
  jpdr_prog u_jpdr_prog (.o_tck(tck), .o_tdi(tdi), .o_state(state),
    .o_ir(ir), .i_tdo(tdo));
  jpdr_top #(.P_TOUT_SHORT_CYC(20'h8), .P_TOUT_LONG_CYC(20'h10)) u_jpdr_top (
    .I_CLK_SYS(clk), .I_RESET(rst), .I_TCK(tck), .I_TDI(tdi),
    .I_TAP_STATE(state), .I_TAP_IR(ir), .O_TDO(tdo), .O_TDO_OE(tdo_oe),
    .I_TOUT_SEL(tout_sel), .O_CORE_RESET(core_rst), .O_PROG_EN(prog_en),
    .O_CMD_WORD(cmd_word), .O_CMD_CLK(cmd_clk), .O_MEM_MODE(mem_mode),
    .O_MEM_ADDR(mem_addr), .O_MEM_WDATA(mem_wdata), .O_MEM_ERASE(erase),
    .O_MEM_LATCH(latch), .O_MEM_WRPAGE(wrpage), .O_MEM_RD(rd),
    .O_MEM_BYTE_HI(byte_hi), .I_MEM_READY(mem_ready),
    .I_MEM_RDATA(mem_rdata), .O_PAGE_ADDR(page_addr),
    .O_PAGE_WDATA(page_wdata), .O_PAGE_WSTB(wstb), .O_PAGE_RSTB(rstb),
    .I_PAGE_RDATA(page_rdata));
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cmd_clk === 1'b1) c_cmd <= c_cmd + 1;
    if (erase === 1'b1) c_er <= c_er + 1;
    if (latch === 1'b1) c_lat <= c_lat + 1;
    if (wrpage === 1'b1) c_wr <= c_wr + 1;
    if (rd === 1'b1) c_rd <= c_rd + 1;
    if (wstb === 1'b1) c_ws <= c_ws + 1;
    if (rstb === 1'b1) c_rs <= c_rs + 1;
    if (tdo_oe === 1'b1) c_oe <= c_oe + 1;
    if (wstb === 1'b1) pg[page_addr] <= page_wdata;
    if (core_rst === 1'b1) rst_len <= rst_len + 1;
    if (cyc == 99000) begin
      n_errors = n_errors + 1;
      conclude;
    end
  end
  task chk(input [15:0] got, input [15:0] exp, input [8*12:1] what);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("CHECK FAILED t=%0t %0s: %h not %h", $time, what, got, exp);
      end
    end
  endtask
  task cmd(input [14:0] w);
    u_jpdr_prog.scan(`JPDR_IR_CMD, 15, {1'b0, w}, r);
  endtask
  task t_reset;
    integer s, l0, dd;
    integer d [0:3];
    begin
      for (s = 0; s < 4; s = s + 1) begin
        @(negedge clk) tout_sel = s[1:0];
        u_jpdr_prog.scan(`JPDR_IR_RESET, 1, 16'h0001, r);
        chk(core_rst, 1, "reset held");
        l0 = rst_len;
        u_jpdr_prog.scan(`JPDR_IR_RESET, 1, 16'h0000, r);
        chk(core_rst, 0, "reset freed");
        d[s] = rst_len - l0;
      end
      for (s = 1; s < 4; s = s + 1) begin
        dd = d[s] - d[0] - (s == 1 ? 8 : 16);
        chk({15'h0, dd >= -1 && dd <= 1}, 1, "time-out");
      end
      $display("t_reset done");
    end
  endtask
  task t_unlock;
    integer o0;
    begin
      chk(prog_en, 0, "unlock rst");
      u_jpdr_prog.scan(`JPDR_IR_RESET, 1, 16'h0001, r);
      cmd({`JPDR_OP_ENTER, `JPDR_ENTER_FWR});
      chk(mem_mode, 0, "locked cmd");
      o0 = c_oe;
      u_jpdr_prog.scan(`JPDR_IR_UNLOCK, 16, 16'ha371, r);
      chk(prog_en, 0, "bad sig");
      // tdo driven for 16 tck periods of 31.25 cycles each
      o0 = c_oe - o0;
      chk({15'h0, o0 >= 499 && o0 <= 501}, 1, "tdo enable");
      u_jpdr_prog.scan(`JPDR_IR_UNLOCK, 16, 16'ha370, r);
      chk(prog_en, 1, "good sig");
      $display("t_unlock done");
    end
  endtask
  task t_modes;
    integer i, c0;
    begin
      for (i = 0; i < 6; i = i + 1) begin
        c0 = c_cmd;
        cmd({`JPDR_OP_ENTER, ENT_D[47-8*i -: 8]});
        chk(cmd_word, {`JPDR_OP_ENTER, ENT_D[47-8*i -: 8]},
          "cmd word");
        chk(16'(c_cmd - c0), 1, "cmd clk");
        chk(mem_mode, ENT_M[17-3*i -: 3], "mode");
      end
      $display("t_modes done");
    end
  endtask
  task t_fwrite;
    integer l0;
    begin
      cmd(15'h2310);
      cmd(15'h0712);
      cmd(15'h0334);
      chk(mem_addr, 16'h1234, "f addr");
      cmd(15'h13a5);
      cmd(15'h175c);
      chk(mem_wdata, 16'h5ca5, "f data");
      l0 = c_lat + c_wr;
      cmd(15'h3700);
      cmd(15'h7700);
      cmd(15'h3700);
      chk(16'(c_lat - l0), 1, "f latch");
      cmd(15'h3500);
      cmd(15'h3700);
      chk(16'(c_lat + c_wr - l0), 2, "f write");
      @(negedge clk) mem_ready = 1'b0;
      cmd(15'h3700);
      cmd(15'h3700);
      chk(r[9], 0, "f busy");
      @(negedge clk) mem_ready = 1'b1;
      cmd(15'h3700);
      cmd(15'h3700);
      chk(r[9], 1, "f ready");
      $display("t_fwrite done");
    end
  endtask
  task t_erase;
    integer e0;
    begin
      cmd(15'h2380);
      e0 = c_er;
      cmd(15'h3180);
      cmd(15'h3380);
      cmd(15'h3380);
      chk(16'(c_er - e0), 1, "erase");
      cmd(15'h3380);
      chk(r[9], 1, "erase poll");
      $display("t_erase done");
    end
  endtask
  task t_ewrite;
    integer l0, e0;
    begin
      cmd(15'h2311);
      cmd(15'h0700);
      cmd(15'h033f);
      cmd(15'h13c6);
      chk(mem_addr, 16'h003f, "e addr");
      chk(mem_wdata[7:0], 16'h00c6, "e data");
      l0 = c_lat + c_wr;
      e0 = c_er;
      cmd(15'h3700);
      cmd(15'h7700);
      cmd(15'h3700);
      cmd(15'h3300);
      cmd(15'h3100);
      cmd(15'h3300);
      chk(16'(c_lat + c_wr - l0), 2, "e write");
      chk(16'(c_er - e0), 0, "e no erase");
      $display("t_ewrite done");
    end
  endtask
  task t_read;
    integer r0;
    begin
      cmd(15'h2302);
      cmd(15'h0701);
      cmd(15'h0380);
      chk(mem_addr, 16'h0180, "r addr");
      r0 = c_rd;
      cmd(15'h3200);
      cmd(15'h3600);
      chk(r[7:0], 16'h005a, "r low");
      chk(byte_hi, 1, "r hi sel");
      cmd(15'h3700);
      chk(r[7:0], 16'h00c3, "r high");
      chk(16'(c_rd - r0), 1, "r count");
      cmd(15'h2303);
      cmd(15'h0700);
      cmd(15'h0307);
      chk(mem_addr, 16'h0007, "ee addr");
      cmd(15'h3200);
      cmd(15'h3300);
      chk(r[7:0], 16'h005a, "ee data");
      $display("t_read done");
    end
  endtask
  task t_pload;
    integer k, w0;
    begin
      w0 = c_ws;
      u_jpdr_prog.page(`JPDR_IR_PLOAD, 1024);
      chk(16'(c_ws - w0), 128, "load bytes");
      for (k = 0; k < 128; k = k + 1)
        chk(pg[k], k[7:0] ^ 8'h5a, "load data");
      $display("t_pload done");
    end
  endtask
  task t_pread;
    integer k, p0;
    begin
      p0 = c_rs;
      u_jpdr_prog.page(`JPDR_IR_PREAD, 1032);
      chk(16'(c_rs - p0), 129, "read bytes");
      for (k = 0; k < 128; k = k + 1)
        chk(u_jpdr_prog.q_page[8+8*k +: 8], {1'b1, k[6:0]} ^ 8'h3c,
          "read data");
      u_jpdr_prog.scan(`JPDR_IR_UNLOCK, 16, 16'h0000, r);
      chk(prog_en, 0, "relock");
      $display("t_pread done");
    end
  endtask
  task conclude;
    begin
      $display("checks %0d mismatches %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  initial begin
    repeat (4) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    t_reset;
    t_unlock;
    t_modes;
    t_fwrite;
    t_erase;
    t_ewrite;
    t_read;
    t_pload;
    t_pread;
    conclude;
  end
endmodule
